// ===== design/wdg_params.svh
`ifndef WDG_PARAMS_SVH
`define WDG_PARAMS_SVH

// register indexes; byte address is four times the index
`define WDG_CTRL_INDEX     6'h2a
`define WDG_STATUS_INDEX   6'h2b
`define WDG_MASK_INDEX     6'h2c
`define WDG_ADDR_W         8

// control register layout and reset value
`define WDG_CTRL_RESET     8'h7f
`define WDG_COUNT_RESET    7'h7f
`define WDG_ACTIVE_BIT     7
`define WDG_TOP_BIT        6
`define WDG_ROLL_FROM      7'h40

// sticky event bits
`define WDG_EV_TIMEOUT     0
`define WDG_EV_SOFT        1
`define WDG_EV_HALT        2
`define WDG_EV_ROLL        3
`define WDG_EV_W           4

// timing
`define WDG_CLK_MHZ        200
`define WDG_PRESCALE       16384
`define WDG_RESET_PULSE_NS 30000
`define WDG_RESET_PULSE_CYCLES (`WDG_RESET_PULSE_NS * `WDG_CLK_MHZ / 1000)
`define WDG_WAKE_SHORT     13'h0100
`define WDG_WAKE_LONG      13'h1000

// axi responses
`define WDG_RESP_OKAY      2'h0
`define WDG_RESP_SLVERR    2'h2

`endif

// ===== design/wdg_pkg.sv
package wdg_pkg;

    typedef enum logic [2:0] {
        run_st,
        halt_once_st,
        halted_st,
        active_halt_st,
        wake_wait_st
    } halt_state_e;

    typedef logic [6:0] count_t;

endpackage

// ===== design/wdg_prescaler.sv
`timescale 1ns/10ps
`include "wdg_params.svh"

module wdg_prescaler #(
    parameter int DIV = `WDG_PRESCALE
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick
);

    localparam int W = $clog2(DIV);

    logic [W-1:0] div_cnt;
    wire          wrap = (div_cnt == W'(DIV - 1));

    // free running: no control write ever restarts it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= wrap ? '0 : div_cnt + W'(1);
            tick    <= wrap;
        end
    end

endmodule

// ===== design/windowed_watchdog_downcounter.sv
// Summary of operation
// - count decrements once per 16384 clocks from a free-running prescaler
// - active watchdog rolling from 40h to 3Fh starts a reset pulse
// - counter keeps decrementing when inactive; rollover then gives no reset
// - active bit clears only on reset; software can set, never clear it
// - write setting active with top bit zero forces a software reset
// - low six count bits give 64 timeout steps before reset
// - control writes never restart the prescaler
// - halt while active, timer irq off, halt option set gives reset
// - plain halt: one more decrement, stop, resume after delay on irq
// - active halt: counter stops, resumes on irq or delayed after reset
// - hardware option makes the watchdog permanently active
// - slow and wait modes do not affect counting or reset
// - control reads active at bit 7, count at 6:0, resets to 7Fh
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "wdg_params.svh"

module windowed_watchdog_downcounter
    import wdg_pkg::*;
#(
    parameter int PRESCALE_CYCLES    = `WDG_PRESCALE,
    parameter int RESET_PULSE_CYCLES = `WDG_RESET_PULSE_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // axi4-lite slave
    input  wire logic [`WDG_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`WDG_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // cpu side, same clock
    input  wire logic                   halt_exec,
    input  wire logic                   ext_irq,
    input  wire logic                   osc_irq,
    input  wire logic                   clock_timer_irq_enable,
    // option byte straps, asynchronous
    input  wire logic                   halt_reset_option,
    input  wire logic                   hw_watchdog_option,
    input  wire logic                   wake_delay_long,
    // outputs
    output logic                        mcu_reset_n,
    output logic                        irq
);

    function automatic logic reg_hit(input logic [`WDG_ADDR_W-1:0] addr,
                                     input logic [5:0] index);
        reg_hit = (addr == {index, 2'h0});
    endfunction

    // option strap synchronisers
    // straps reset low; the hardware option lands two cycles after release
    logic [2:0] opt_meta;
    logic [2:0] opt_sync;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opt_meta <= 3'h0;
            opt_sync <= 3'h0;
        end else begin
            opt_meta <= {wake_delay_long, hw_watchdog_option,
                         halt_reset_option};
            opt_sync <= opt_meta;
        end
    end

    wire halt_opt = opt_sync[0];
    wire hw_opt   = opt_sync[1];
    wire long_opt = opt_sync[2];

    // prescaler
    logic tick;

    wdg_prescaler #(
        .DIV     (PRESCALE_CYCLES)
    ) u_prescaler (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // write channel holding
    logic                   aw_held;
    logic                   w_held;
    logic [`WDG_ADDR_W-1:0] waddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;

    wire aw_take     = s_axi_awvalid && s_axi_awready;
    wire w_take      = s_axi_wvalid && s_axi_wready;
    wire wr_fire     = aw_held && w_held && !s_axi_bvalid;
    wire next_aw_held = aw_take | (aw_held & ~wr_fire);
    wire next_w_held  = w_take | (w_held & ~wr_fire);

    wire hit_ctrl_w = reg_hit(waddr, `WDG_CTRL_INDEX);
    wire hit_stat_w = reg_hit(waddr, `WDG_STATUS_INDEX);
    wire hit_mask_w = reg_hit(waddr, `WDG_MASK_INDEX);
    wire wr_mapped  = hit_ctrl_w | hit_stat_w | hit_mask_w;
    wire lane0      = wstrb[0];

    wire ctrl_wr = wr_fire && hit_ctrl_w && lane0;
    wire stat_wr = wr_fire && hit_stat_w && lane0;
    wire mask_wr = wr_fire && hit_mask_w && lane0;

    // watchdog core state
    count_t                 count;
    logic                   active;
    halt_state_e            state;
    halt_state_e            next_state;
    logic [12:0]            wake_cnt;
    logic [12:0]            next_wake;
    logic [15:0]            pulse_cnt;
    logic [`WDG_EV_W-1:0]   status;
    logic [`WDG_EV_W-1:0]   mask;

    wire eff_active = active | hw_opt;
    // short wake delay unless the long strap is set
    wire [12:0] wake_lim = long_opt ? `WDG_WAKE_LONG : `WDG_WAKE_SHORT;

    // slow and wait modes have no path into this enable
    wire count_en = tick && (state == run_st || state == halt_once_st);
    wire at_roll  = count_en && (count == `WDG_ROLL_FROM);

    wire timeout_ev = at_roll && eff_active;
    wire roll_ev    = at_roll && !eff_active;
    wire soft_ev    = ctrl_wr && !wdata[`WDG_TOP_BIT]
                      && (eff_active || wdata[`WDG_ACTIVE_BIT]);
    wire halt_ev    = halt_exec && state == run_st && eff_active
                      && !clock_timer_irq_enable && halt_opt;
    wire trig       = timeout_ev | soft_ev | halt_ev;

    wire [`WDG_EV_W-1:0] events = {roll_ev, halt_ev, soft_ev, timeout_ev};
    // set wins over a clear in the same cycle
    wire [`WDG_EV_W-1:0] clr_bits    = stat_wr ? wdata[`WDG_EV_W-1:0] : '0;
    wire [`WDG_EV_W-1:0] next_status = (status & ~clr_bits) | events;
    wire [`WDG_EV_W-1:0] next_mask   = mask_wr ? wdata[`WDG_EV_W-1:0] : mask;
    wire                 next_irq    = |(next_status & next_mask);

    // a trigger during a running pulse does not stretch it
    wire [15:0] pulse_len  = 16'(RESET_PULSE_CYCLES);
    wire [15:0] next_pulse = (trig && pulse_cnt == 16'h0) ? pulse_len :
                             (pulse_cnt != 16'h0) ? pulse_cnt - 16'h1 :
                             16'h0;

    // halt sequencing
    always_comb begin
        next_state = state;
        next_wake  = wake_cnt;
        unique case (state)
            run_st: begin
                if (halt_exec && !halt_ev) begin
                    if (clock_timer_irq_enable)
                        next_state = active_halt_st;
                    else
                        next_state = halt_once_st;
                end
            end
            halt_once_st: begin
                if (tick)
                    next_state = halted_st;
            end
            halted_st: begin
                if (ext_irq) begin
                    next_state = wake_wait_st;
                    next_wake  = wake_lim;
                end
            end
            active_halt_st: begin
                if (osc_irq || ext_irq)
                    next_state = run_st;
            end
            wake_wait_st: begin
                if (wake_cnt > wake_lim)
                    next_wake = wake_lim;
                else if (wake_cnt <= 13'h1) begin
                    next_wake  = 13'h0;
                    next_state = run_st;
                end else
                    next_wake = wake_cnt - 13'h1;
            end
        endcase
    end

    // after reset, counting waits out the oscillator start delay
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= wake_wait_st;
            wake_cnt <= `WDG_WAKE_LONG;
        end else begin
            state    <= next_state;
            wake_cnt <= next_wake;
        end
    end

    // a write in the tick cycle wins; that decrement is lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count  <= `WDG_COUNT_RESET;
            active <= 1'b0;
        end else begin
            if (ctrl_wr)
                count <= wdata[6:0];
            else if (count_en)
                count <= count - 7'h1;
            if (ctrl_wr)
                active <= active | wdata[`WDG_ACTIVE_BIT];
        end
    end

    // reset pulse, status and interrupt
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_cnt   <= 16'h0;
            mcu_reset_n <= 1'b1;
            status      <= '0;
            mask        <= '0;
            irq         <= 1'b0;
        end else begin
            pulse_cnt   <= next_pulse;
            mcu_reset_n <= (next_pulse == 16'h0);
            status      <= next_status;
            if (mask_wr)
                mask <= wdata[`WDG_EV_W-1:0];
            irq <= next_irq;
        end
    end

    // write channels; the two halves are taken in either order
    // a second write waits in the held halves until bready frees them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            waddr         <= '0;
            wdata         <= 32'h0;
            wstrb         <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WDG_RESP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held;
            s_axi_wready  <= !next_w_held;
            if (aw_take)
                waddr <= s_axi_awaddr;
            if (w_take) begin
                wdata <= s_axi_wdata;
                wstrb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read path: live count is visible, not a snapshot
    // unmapped reads return zero with an error response
    wire hit_ctrl_r = reg_hit(s_axi_araddr, `WDG_CTRL_INDEX);
    wire hit_stat_r = reg_hit(s_axi_araddr, `WDG_STATUS_INDEX);
    wire hit_mask_r = reg_hit(s_axi_araddr, `WDG_MASK_INDEX);
    wire rd_mapped  = hit_ctrl_r | hit_stat_r | hit_mask_r;
    wire [31:0] rd_word =
        hit_ctrl_r ? {24'h0, active, count} :
        hit_stat_r ? {28'h0, status} :
        hit_mask_r ? {28'h0, mask} : 32'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `WDG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ===== sim/wdg_asserts.sv
`timescale 1ns/10ps
module wdg_asserts #(
    parameter int RESET_PULSE_CYCLES = 6000
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        mcu_reset_n,
    input wire logic        irq
);
    // counter, since a repetition of thousands would stall the tools
    int low_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk)
        low_cnt <= (sys_rst || mcu_reset_n) ? 0 : low_cnt + 1;
    pulse_len_a: assert property (
        $rose(mcu_reset_n) |-> low_cnt == RESET_PULSE_CYCLES)
        else $error("reset pulse length wrong");
    pulse_max_a: assert property (
        low_cnt <= RESET_PULSE_CYCLES) else $error("reset pulse too long");
    rst_idle_a: assert property (disable iff (1'b0)
        sys_rst |=> mcu_reset_n && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    aw_take_a: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    ar_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rdata_width_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
    cover property ($fell(mcu_reset_n));
    cover property ($rose(irq));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind windowed_watchdog_downcounter wdg_asserts #(
    .RESET_PULSE_CYCLES (RESET_PULSE_CYCLES)
) u_asserts (.*);

// ===== sim/windowed_watchdog_downcounter_bench.sv
`timescale 1ns/10ps
module windowed_watchdog_downcounter_bench;
    localparam int PS = 16;
    logic        clk = 1'h0, sys_rst = 1'h1;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv, a;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        halt_exec = 1'h0, ext_irq = 1'h0, osc_irq = 1'h0;
    logic        clock_timer_irq_enable = 1'h0, halt_reset_option = 1'h0;
    logic        hw_watchdog_option = 1'h0, wake_delay_long = 1'h0;
    logic        mcu_reset_n, irq;
    int          miscompares = 0, cmp_count = 0, n;

    windowed_watchdog_downcounter #(
        .PRESCALE_CYCLES    (PS),
        .RESET_PULSE_CYCLES (4)
    ) u_dut (.*);

    initial forever #2.5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tmo(input int k, lim);
        if (k >= lim) begin
            miscompares++;
            $display("[ERR] wait expected done seen timeout");
            test_done;
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] ad, d);
        int k;
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        // ready raised late so the slave must hold its answer
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'h1;
        end
        s_axi_bready <= 1'h0;
        rr = s_axi_bresp;
        tmo(k, 40);
    endtask

    task automatic rd(input logic [7:0] ad);
        int k;
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
        s_axi_rready <= 1'h0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        tmo(k, 40);
    endtask

    task automatic wait_pulse(input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (!mcu_reset_n) break;
        end
        tmo(n, lim);
    endtask

    // wait covers the 256-cycle hold after reset
    task automatic rst;
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (300) @(posedge clk);
    endtask

    task automatic t_regs;
        rd(8'ha8);
        chk("ctrl reset", 32'h7f, rv);
        rd(8'h10);
        chk("unmapped resp", 2'h2, rr);
        chk("unmapped data", 0, rv);
        wr(8'h10, 8'h01);
        chk("unmapped wr resp", 2'h2, rr);
        wr(8'hb0, 8'h0f);
        chk("mask wr resp", 2'h0, rr);
        rd(8'hb0);
        chk("mask", 32'h0f, rv);
        $display("regs done");
    endtask

    task automatic t_roll;
        int lows = 0;
        for (n = 0; n < 1500; n++) begin
            @(posedge clk);
            if (!mcu_reset_n) lows++;
        end
        chk("idle reset", 0, lows);
        rd(8'hac);
        chk("roll flag", 32'h8, rv);
        chk("irq set", 1, irq);
        wr(8'hac, 8'h08);
        rd(8'hac);
        chk("flag clear", 0, rv);
        chk("irq clear", 0, irq);
        $display("roll done");
    endtask

    task automatic t_timeout;
        wr(8'ha8, 8'hc3);
        rd(8'ha8);
        chk("load", 1, rv == 32'hc3 || rv == 32'hc2);
        wait_pulse(100);
        chk("window", 1, n >= 3 * PS - 8 && n <= 4 * PS + 4);
        rd(8'hac);
        chk("timeout flag", 32'h1, rv & 32'h1);
        rst;
        rd(8'ha8);
        chk("active reset", 0, rv & 32'h80);
        wr(8'ha8, 8'hff);
        wr(8'ha8, 8'h7f);
        rd(8'ha8);
        chk("active kept", 32'h80, rv & 32'h80);
        chk("no reset", 1, mcu_reset_n);
        rst;
        $display("timeout done");
    endtask

    task automatic t_soft_halt;
        wr(8'ha8, 8'h80);
        wait_pulse(10);
        rd(8'hac);
        chk("soft flag", 32'h2, rv & 32'h2);
        rst;
        halt_reset_option <= 1'h1;
        wr(8'ha8, 8'hff);
        halt_exec <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h0;
        wait_pulse(10);
        rd(8'hac);
        chk("halt flag", 32'h4, rv & 32'h4);
        halt_reset_option <= 1'h0;
        rst;
        $display("soft halt done");
    endtask

    // plain halt: one decrement, frozen, then a wake delay after the irq
    task automatic t_halt_wake;
        wr(8'ha8, 8'hff);
        halt_exec <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h0;
        repeat (2 * PS) @(posedge clk);
        rd(8'ha8);
        chk("halt once", 1, rv == 32'hfe || rv == 32'hfd);
        a = rv;
        repeat (4 * PS) @(posedge clk);
        rd(8'ha8);
        chk("halt frozen", a, rv);
        ext_irq <= 1'h1;
        @(posedge clk);
        ext_irq <= 1'h0;
        repeat (200) @(posedge clk);
        rd(8'ha8);
        chk("wake delay", a, rv);
        repeat (100 + 2 * PS) @(posedge clk);
        rd(8'ha8);
        chk("wake resumed", 1, rv < a);
        rst;
        $display("halt wake done");
    endtask

    task automatic t_ahalt_hw;
        clock_timer_irq_enable <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h0;
        rd(8'ha8);
        a = rv;
        repeat (4 * PS) @(posedge clk);
        rd(8'ha8);
        chk("frozen", a, rv);
        osc_irq <= 1'h1;
        @(posedge clk);
        osc_irq <= 1'h0;
        repeat (4 * PS) @(posedge clk);
        rd(8'ha8);
        chk("resumed", 1, rv < a);
        clock_timer_irq_enable <= 1'h0;
        hw_watchdog_option <= 1'h1;
        rst;
        wr(8'ha8, 8'h41);
        wait_pulse(3 * PS);
        rd(8'hac);
        chk("hw flag", 32'h1, rv & 32'h1);
        hw_watchdog_option <= 1'h0;
        rst;
        $display("ahalt hw done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        t_regs;
        t_roll;
        t_timeout;
        t_soft_halt;
        t_halt_wake;
        t_ahalt_hw;
        test_done;
    end
endmodule
